// File: adc_channel_ready_irq_regs.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module adc_channel_ready_irq_regs
  import adc_regs_pkg::*;
#(
  parameter logic [31:0] CHANNELS_PRESENT = 32'hFFFF_FFFF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Conversion cores
  input wire logic [31:0] result_landed,
  input wire logic [31:0] result_buffer_read,
  // Interrupts and trigger selections
  output logic [31:0] channel_irq,
  output logic common_irq,
  output logic irq,
  output logic [31:0][4:0] channel_trigger_source
);

  // Software-visible registers
  logic [15:0] irq_enable_low;
  logic [15:0] next_irq_enable_low;
  logic [15:0] irq_enable_high;
  logic [15:0] next_irq_enable_high;
  logic [31:0] ready;
  logic [31:0] next_ready;
  logic [31:0] irq_status;
  logic [31:0] next_irq_status;
  logic [31:0] irq_mask;
  logic [31:0] next_irq_mask;
  logic [TRIG_REGS-1:0][15:0] trigger;
  logic [TRIG_REGS-1:0][15:0] next_trigger;

  // Write channel
  logic have_aw;
  logic next_have_aw;
  logic have_w;
  logic next_have_w;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;

  // Read channel
  logic rvalid;
  logic next_rvalid;
  read_answer_t rans;
  read_answer_t next_rans;
  logic [31:0] read_word;

  // Decoded helpers
  logic [31:0] enable_all;
  logic [31:0] ready_rise;
  logic [31:0] wmask;
  logic do_write;
  logic write_hit;
  logic [3:0] w_index;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic is_trigger(input logic [7:0] a);
    is_trigger = a >= OFF_TRIGGER_BASE && a <= OFF_TRIGGER_LAST;
  endfunction

  function automatic logic [3:0] trig_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_TRIGGER_BASE;
    trig_index = d[5:2];
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = a[1:0] == 2'h0 && (a <= OFF_IRQ_MASK || is_trigger(a));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = strb_mask(s);
    merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction

  function automatic logic [4:0] trigger_field(input logic [15:0] w,
    input logic odd);
    trigger_field = odd ? w[TRIG_HI_LSB +: 5] : w[TRIG_LO_LSB +: 5];
  endfunction

  // Absent channels hold no enable bits
  assign enable_all = {irq_enable_high, irq_enable_low} & CHANNELS_PRESENT;
  assign channel_irq = ready & enable_all;
  assign common_irq = |channel_irq;
  // Level output; stays high until status is cleared or masked
  assign irq = |(irq_status & irq_mask);
  // A held flag does not set status again after a clear
  assign ready_rise = result_landed & CHANNELS_PRESENT & ~ready;

  // Even channels take the low field, odd ones the high field
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      channel_trigger_source[c] = trigger_field(trigger[c / 2], c[0]);
    end
  end

  // One transfer in flight per direction keeps the slave small
  assign s_axi_awready = !have_aw && !bvalid;
  assign s_axi_wready = !have_w && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rans.data;
  assign s_axi_rresp = rans.resp;

  // Write channel: address and data may arrive in either order
  always_comb begin
    next_have_aw = have_aw;
    next_have_w = have_w;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_have_aw = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_have_w = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (have_aw && have_w) begin
      next_have_aw = 1'b0;
      next_have_w = 1'b0;
      next_bvalid = 1'b1;
      if (is_mapped(aw_addr)) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Unmapped writes are answered but change nothing
  assign do_write = have_aw && have_w;
  assign write_hit = do_write && is_mapped(aw_addr);
  assign wmask = strb_mask(w_strb);
  assign w_index = trig_index(aw_addr);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      have_aw <= next_have_aw;
      have_w <= next_have_w;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // Enable registers
  always_comb begin
    next_irq_enable_low = irq_enable_low;
    next_irq_enable_high = irq_enable_high;
    if (write_hit && aw_addr == OFF_IRQ_ENABLE_LOW) begin
      next_irq_enable_low = merge16(irq_enable_low, w_data, w_strb);
    end
    if (write_hit && aw_addr == OFF_IRQ_ENABLE_HIGH) begin
      next_irq_enable_high = merge16(irq_enable_high, w_data, w_strb);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_low <= RESET_IRQ_ENABLE;
      irq_enable_high <= RESET_IRQ_ENABLE;
    end else begin
      irq_enable_low <= next_irq_enable_low;
      irq_enable_high <= next_irq_enable_high;
    end
  end

  // Ready flags; words at the ready offsets take no writes
  always_comb begin
    next_ready = ready & ~result_buffer_read;
    // A landing result beats a same-cycle buffer read
    next_ready = next_ready | result_landed;
    next_ready = next_ready & CHANNELS_PRESENT;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready <= RESET_READY;
    end else begin
      ready <= next_ready;
    end
  end

  // Sticky event bits behind a mask
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (write_hit && aw_addr == OFF_IRQ_STATUS) begin
      next_irq_status = irq_status & ~(w_data & wmask);
    end
    if (write_hit && aw_addr == OFF_IRQ_MASK) begin
      next_irq_mask = (irq_mask & ~wmask) | (w_data & wmask);
    end
    // A new result wins over a same-cycle software clear
    next_irq_status = next_irq_status | (ready_rise & enable_all);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= RESET_STATUS;
      irq_mask <= RESET_MASK;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // Trigger words; the gaps between the fields stay zero
  always_comb begin
    next_trigger = trigger;
    if (write_hit && is_trigger(aw_addr)) begin
      next_trigger[w_index] = merge16(trigger[w_index], w_data, w_strb)
        & TRIG_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trigger <= {TRIG_REGS{RESET_TRIGGER}};
    end else begin
      trigger <= next_trigger;
    end
  end

  // Read data decode; misaligned and unmapped words read zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (is_mapped(s_axi_araddr) && is_trigger(s_axi_araddr)) begin
      read_word = zext16(trigger[trig_index(s_axi_araddr)]
        & TRIG_WRITE_MASK);
    end else begin
      unique case (s_axi_araddr)
        OFF_IRQ_ENABLE_LOW: read_word = zext16(enable_all[15:0]);
        OFF_IRQ_ENABLE_HIGH: read_word = zext16(enable_all[31:16]);
        OFF_READY_LOW: read_word = zext16(ready[15:0]);
        OFF_READY_HIGH: read_word = zext16(ready[31:16]);
        OFF_IRQ_STATUS: read_word = irq_status;
        OFF_IRQ_MASK: read_word = irq_mask;
        default: read_word = 32'h0000_0000;
      endcase
    end
  end

  // Read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rans = rans;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      if (is_mapped(s_axi_araddr)) begin
        next_rans.resp = RESP_OKAY;
      end else begin
        next_rans.resp = RESP_SLVERR;
      end
      next_rans.data = read_word;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rans <= '0;
    end else begin
      rvalid <= next_rvalid;
      rans <= next_rans;
    end
  end

endmodule
`default_nettype wire

// File: adc_regs_pkg.sv
package adc_regs_pkg;

  localparam int unsigned NUM_CHANNELS = 32;

  // Byte offsets of the register words
  localparam logic [7:0] OFF_IRQ_ENABLE_LOW = 8'h00;
  localparam logic [7:0] OFF_IRQ_ENABLE_HIGH = 8'h04;
  localparam logic [7:0] OFF_READY_LOW = 8'h08;
  localparam logic [7:0] OFF_READY_HIGH = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_TRIGGER_BASE = 8'h20;
  localparam logic [7:0] OFF_TRIGGER_LAST = 8'h5C;

  // Trigger select layout: two 5-bit fields per word
  localparam int unsigned TRIG_REGS = 16;
  localparam int unsigned TRIG_LO_LSB = 0;
  localparam int unsigned TRIG_HI_LSB = 8;
  localparam logic [15:0] TRIG_WRITE_MASK = 16'h1F1F;

  // Reset values
  localparam logic [15:0] RESET_IRQ_ENABLE = 16'h0000;
  localparam logic [15:0] RESET_TRIGGER = 16'h0000;
  localparam logic [31:0] RESET_READY = 32'h0000_0000;
  localparam logic [31:0] RESET_STATUS = 32'h0000_0000;
  localparam logic [31:0] RESET_MASK = 32'h0000_0000;

  // Trigger source encodings
  typedef enum logic [4:0] {
    TRIG_NONE = 5'h00,
    TRIG_SOFTWARE = 5'h01,
    TRIG_SOFTWARE_LEVEL = 5'h02,
    TRIG_RESERVED = 5'h03,
    TRIG_EXTERNAL_PIN = 5'h1F
  } trigger_source_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] addr_write_data;
  } unused_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } read_answer_t;

endpackage

// File: adc_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module adc_regs_checker
  import adc_regs_pkg::*;
#(
  parameter logic [31:0] CHANNELS_PRESENT = 32'hFFFF_FFFF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  // Cores and outputs
  input wire logic [31:0] result_landed,
  input wire logic [31:0] result_buffer_read,
  input wire logic [31:0] channel_irq,
  input wire logic common_irq,
  input wire logic [31:0][4:0] channel_trigger_source
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence r_held; s_axi_rvalid && !s_axi_rready; endsequence
  common_or_a: assert property (common_irq == (|channel_irq))
    else $error("common irq differs from channel irqs");
  absent_quiet_a: assert property ((channel_irq & ~CHANNELS_PRESENT) == 0)
    else $error("absent channel raised an irq");
  read_clears_a: assert property ((result_buffer_read & ~result_landed) != 0 |=>
    (channel_irq & $past(result_buffer_read & ~result_landed)) == 0)
    else $error("buffer read left irq set");
  irq_cause_a: assert property ((channel_irq & ~$past(channel_irq)) != 0 |->
    $past(result_landed) != 0 || $rose(s_axi_bvalid))
    else $error("channel irq rose without cause");
  trig_by_write_a: assert property (!$stable(channel_trigger_source) |->
    $rose(s_axi_bvalid))
    else $error("trigger source changed without write");
  reset_clear_a: assert property ($rose(rst_b) |->
    channel_trigger_source == '0 && channel_irq == 32'h0)
    else $error("state not clear after reset");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (r_held |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
endmodule
`default_nettype wire

// File: adc_channel_ready_irq_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_channel_ready_irq_regs_bench;
  import adc_regs_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d, q; logic [1:0] r;} row_t;
  // Channel 31 left out to exercise absent bits
  localparam logic [31:0] PRESENT = 32'h7FFF_FFFF;
  row_t rows [7] = '{
    '{OFF_IRQ_ENABLE_LOW, 32'hFFFF_FFFF, 32'h0000_FFFF, RESP_OKAY},
    '{OFF_IRQ_ENABLE_HIGH, 32'hFFFF_FFFF, 32'h0000_7FFF, RESP_OKAY},
    '{OFF_READY_HIGH, 32'hFFFF_FFFF, 32'h0, RESP_OKAY},
    '{OFF_TRIGGER_BASE, 32'hFFFF_FFFF, 32'h0000_1F1F, RESP_OKAY},
    '{OFF_TRIGGER_LAST, 32'h0000_1F02, 32'h0000_1F02, RESP_OKAY},
    '{8'h18, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR},
    '{8'h21, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR}};
  trigger_source_t codes [5] = '{TRIG_NONE, TRIG_SOFTWARE,
    TRIG_SOFTWARE_LEVEL, TRIG_RESERVED, TRIG_EXTERNAL_PIN};
  logic sys_clk = 1'h0, rst_b = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, result_landed = 32'h0;
  logic [31:0] result_buffer_read = 32'h0, s_axi_rdata, channel_irq, got;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, common_irq, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0][4:0] channel_trigger_source;
  int fail_count = 0, compares = 0;
  adc_channel_ready_irq_regs #(.CHANNELS_PRESENT(PRESENT))
    adc_channel_ready_irq_regs_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .result_landed(result_landed),
    .result_buffer_read(result_buffer_read), .channel_irq(channel_irq),
    .common_irq(common_irq), .irq(irq),
    .channel_trigger_source(channel_trigger_source));
  always #10 sys_clk = ~sys_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task end_of_test;
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Wait on the handshakes rather than a fixed latency
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task pulse(input logic [31:0] l, input logic [31:0] b);
    result_landed <= l;
    result_buffer_read <= b;
    @(posedge sys_clk);
    result_landed <= 32'h0;
    result_buffer_read <= 32'h0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    chk(channel_irq, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rsp);
      chk(32'(rsp), 32'(rows[i].r));
      rd(rows[i].a, got, rsp);
      chk(got, rows[i].q);
      chk(32'(rsp), 32'(rows[i].r));
    end
    chk(32'(channel_trigger_source[1]), 32'h1F);
    chk(32'(channel_trigger_source[30]), 32'h02);
    foreach (codes[i]) begin
      wr(OFF_TRIGGER_BASE + 8'h04, 32'(codes[i]), rsp);
      chk(32'(channel_trigger_source[2]), 32'(codes[i]));
    end
    pulse(32'h8000_0008, 32'h0);
    chk(channel_irq, 32'h0000_0008);
    chk(32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h8, rsp);
    chk(32'(irq), 32'h1);
    wr(OFF_IRQ_STATUS, 32'h8, rsp);
    chk(32'(irq), 32'h0);
    rd(OFF_READY_LOW, got, rsp);
    chk(got, 32'h8);
    pulse(32'h0, 32'h8);
    chk(32'(common_irq), 32'h0);
    wr(OFF_IRQ_ENABLE_LOW, 32'h0, rsp);
    pulse(32'h2, 32'h0);
    chk(32'(common_irq), 32'h0);
    rd(OFF_READY_LOW, got, rsp);
    chk(got, 32'h2);
    pulse(32'h4, 32'h4);
    rd(OFF_READY_LOW, got, rsp);
    chk(got, 32'h6);
    rst_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    rd(OFF_IRQ_ENABLE_HIGH, got, rsp);
    chk(got, 32'h0);
    chk(32'(channel_trigger_source[31]), 32'h0);
    end_of_test;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule
bind adc_channel_ready_irq_regs adc_regs_checker
  #(.CHANNELS_PRESENT(CHANNELS_PRESENT)) adc_regs_checker_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rready(s_axi_rready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .result_landed(result_landed),
  .result_buffer_read(result_buffer_read), .channel_irq(channel_irq),
  .common_irq(common_irq), .channel_trigger_source(channel_trigger_source));
`default_nettype wire
